// ### ds3_tx_oh_pkg.sv
// Constants for the DS3 transmit overhead and alarm message controller.
`default_nettype none

package ds3_tx_oh_pkg;

  // Register offsets.
  localparam logic [7:0] CFG_OFFSET = 8'h30;
  localparam logic [7:0] MSG_CTRL_OFFSET = 8'h31;
  localparam logic [7:0] MSG_CODE_OFFSET = 8'h32;

  // Configuration register fields.
  localparam int CFG_YELLOW_BIT = 7;
  localparam int CFG_X_ONES_BIT = 6;
  localparam int CFG_IDLE_BIT = 5;
  localparam int CFG_AIS_BIT = 4;
  localparam int CFG_LOS_BIT = 3;
  localparam int CFG_Y_LOS_BIT = 2;
  localparam int CFG_Y_OOF_BIT = 1;
  localparam int CFG_Y_AIS_BIT = 0;
  localparam logic [7:0] CFG_RESET = 8'h07;

  // Message control and status register fields.
  localparam int CTRL_IRQ_EN_BIT = 4;
  localparam int CTRL_IRQ_ST_BIT = 3;
  localparam int CTRL_ENABLE_BIT = 2;
  localparam int CTRL_GO_BIT = 1;
  localparam int CTRL_BUSY_BIT = 0;

  // Message code register fields.
  localparam int CODE_LSB = 1;
  localparam int CODE_MSB = 6;
  localparam int CODE_W = 6;
  localparam logic [5:0] CODE_RESET = 6'h3F;

  // Message framing: a zero, the code, a zero, then eight ones.
  localparam int MSG_BITS = 16;
  localparam int MSG_REPEATS = 10;
  localparam logic [7:0] MSG_FLAG = 8'hFF;

  // Class of the current outbound bit, given by the framer core.
  localparam logic [2:0] KIND_PAYLOAD = 3'h0;
  localparam logic [2:0] KIND_MFP = 3'h1;
  localparam logic [2:0] KIND_X = 3'h2;
  localparam logic [2:0] KIND_C = 3'h3;
  localparam logic [2:0] KIND_MSG = 3'h4;

  // Subframe that carries the CP-bits.
  localparam logic [2:0] CP_SUBFRAME = 3'h3;

  // Payload pattern phases.
  localparam logic [1:0] PAT_IDLE = 2'h3;

  typedef enum logic [1:0] {
    MSG_IDLE = 2'b00,
    MSG_SEND = 2'b01,
    MSG_DONE = 2'b11
  } msg_state_t;

endpackage

`default_nettype wire

// ### ds3_tx_overhead_alarm_ctrl.sv
// DS3 transmit overhead, alarm pattern and alarm message controller.
//
// How it works
// [RULE1] Yellow control forces every X-bit to zero.
// [RULE2] Yellow ignored under LOS, AIS or idle.
// [RULE3] Force-ones control drives every X-bit high.
// [RULE4] Force-ones ignored under LOS, AIS, idle, yellow.
// [RULE5] Idle: CP-bits zero, X one, 1100 payload.
// [RULE6] Idle ignored under LOS or AIS.
// [RULE7] AIS: C-bits zero, X one, 1010 payload.
// [RULE8] LOS simulation sends continuous all zeros.
// [RULE9] Receiver LOS, OUT_OF_FRAME, AIS raise yellow, each enabled.
// [RULE10] Message sender idle while its enable is low.
// [RULE11] Go sends framed 16-bit message ten times.
// [RULE12] Busy high until tenth message finishes.
// [RULE13] Completion status set at end, cleared on read.
// [RULE14] Completion interrupt gated by its enable bit.
// [RULE15] Code in bits 6..1, reset ones, message slot.
// [RULE16] Reset-upon-read status clears when register read.
// [RULE17] Interrupt high while status and enable both set.
`timescale 1ns/100ps
`default_nettype none

module ds3_tx_overhead_alarm_ctrl
  import ds3_tx_oh_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock, reset and clock enable.
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Register port.
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Receive framer conditions of the same channel.
  input wire logic rx_los_i,
  input wire logic rx_oof_i,
  input wire logic rx_ais_i,
  // Outbound stream from the framer core.
  input wire logic bit_valid_i,
  input wire logic [2:0] bit_kind_i,
  input wire logic [2:0] subframe_i,
  input wire logic tx_bit_i,
  // Outbound stream to the line interface.
  output logic tx_valid_o,
  output logic tx_bit_o,
  // Status and interrupt.
  output logic alarm_msg_busy_o,
  output logic irq_o
);

  logic rst_sync1_q;
  logic rst_sync2_q;
  logic rst_n;

  // Register state.
  logic [7:0] cfg_q;
  logic alarm_msg_irq_enable_q;
  logic alarm_msg_irq_status_q;
  logic alarm_msg_enable_q;
  logic alarm_msg_go_q;
  logic [CODE_W-1:0] alarm_msg_code_q;
  logic [7:0] rdata_q;

  // Message sender state.
  msg_state_t msg_state_q;
  msg_state_t msg_state_d;
  logic [MSG_BITS-1:0] msg_shift_q;
  logic [3:0] bit_cnt_q;
  logic [3:0] rep_cnt_q;
  logic done_evt;
  logic start_evt;
  logic slot_hit;

  // Stream state.
  logic [1:0] pat_phase_q;
  logic tx_bit_q;
  logic tx_valid_q;

  // Decoded controls.
  logic wr_cfg;
  logic wr_ctrl;
  logic wr_code;
  logic rd_ctrl;
  logic simulate_signal_loss;
  logic send_alarm_indication;
  logic send_idle;
  logic yellow_cmd;
  logic force_x_ones;
  logic yellow_on_signal_loss;
  logic yellow_on_out_of_frame;
  logic yellow_on_alarm_indication;
  logic auto_yellow;
  logic out_bit;

  // Reset release through two flip-flops.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_sync2_q <= rst_sync1_q;
    end
  end

  assign rst_n = rst_sync2_q;

  // Address decode.
  assign wr_cfg = wr_i && (addr_i == ADDR_W'(CFG_OFFSET));
  assign wr_ctrl = wr_i && (addr_i == ADDR_W'(MSG_CTRL_OFFSET));
  assign wr_code = wr_i && (addr_i == ADDR_W'(MSG_CODE_OFFSET));
  assign rd_ctrl = rd_i && (addr_i == ADDR_W'(MSG_CTRL_OFFSET));

  // Configuration register.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= CFG_RESET; // [RULE9]
    end else if (ce_i && wr_cfg) begin
      cfg_q <= wdata_i;
    end
  end

  assign simulate_signal_loss = cfg_q[CFG_LOS_BIT];
  assign send_alarm_indication = cfg_q[CFG_AIS_BIT];
  assign send_idle = cfg_q[CFG_IDLE_BIT];
  assign yellow_cmd = cfg_q[CFG_YELLOW_BIT];
  assign force_x_ones = cfg_q[CFG_X_ONES_BIT];
  assign yellow_on_signal_loss = cfg_q[CFG_Y_LOS_BIT];
  assign yellow_on_out_of_frame = cfg_q[CFG_Y_OOF_BIT];
  assign yellow_on_alarm_indication = cfg_q[CFG_Y_AIS_BIT];

  // Receiver conditions each raise a yellow alarm when enabled.
  assign auto_yellow = (rx_los_i && yellow_on_signal_loss) ||
                       (rx_oof_i && yellow_on_out_of_frame) ||
                       (rx_ais_i && yellow_on_alarm_indication); // [RULE9]

  // Message control: enable and interrupt enable.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      alarm_msg_enable_q <= 1'b0;
      alarm_msg_irq_enable_q <= 1'b0;
    end else if (ce_i && wr_ctrl) begin
      alarm_msg_enable_q <= wdata_i[CTRL_ENABLE_BIT];
      alarm_msg_irq_enable_q <= wdata_i[CTRL_IRQ_EN_BIT]; // [RULE14]
    end
  end

  // Go stays pending until the sender accepts it, then clears itself.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      alarm_msg_go_q <= 1'b0;
    end else if (ce_i) begin
      if (wr_ctrl && wdata_i[CTRL_GO_BIT]) begin
        alarm_msg_go_q <= 1'b1;
      end else if (start_evt) begin
        alarm_msg_go_q <= 1'b0;
      end
    end
  end

  // Completion status: a new completion wins over a clear in the same cycle.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      alarm_msg_irq_status_q <= 1'b0;
    end else if (ce_i) begin
      if (done_evt) begin
        alarm_msg_irq_status_q <= 1'b1; // [RULE13]
      end else if (rd_ctrl) begin
        alarm_msg_irq_status_q <= 1'b0; // [RULE16]
      end else if (wr_ctrl && wdata_i[CTRL_IRQ_ST_BIT]) begin
        alarm_msg_irq_status_q <= 1'b0;
      end
    end
  end

  // Message code register.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      alarm_msg_code_q <= CODE_RESET; // [RULE15]
    end else if (ce_i && wr_code) begin
      alarm_msg_code_q <= wdata_i[CODE_MSB:CODE_LSB]; // [RULE15]
    end
  end

  // Read data, valid in the cycle after the read strobe.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (ce_i) begin
      rdata_q <= 8'h00;
      if (rd_i) begin
        case (addr_i)
          ADDR_W'(CFG_OFFSET): begin
            rdata_q <= cfg_q;
          end
          ADDR_W'(MSG_CTRL_OFFSET): begin
            rdata_q[CTRL_IRQ_EN_BIT] <= alarm_msg_irq_enable_q;
            rdata_q[CTRL_IRQ_ST_BIT] <= alarm_msg_irq_status_q;
            rdata_q[CTRL_ENABLE_BIT] <= alarm_msg_enable_q;
            rdata_q[CTRL_GO_BIT] <= alarm_msg_go_q;
            rdata_q[CTRL_BUSY_BIT] <= alarm_msg_busy_o;
          end
          ADDR_W'(MSG_CODE_OFFSET): begin
            rdata_q[CODE_MSB:CODE_LSB] <= alarm_msg_code_q;
          end
          default: begin
            rdata_q <= 8'h00;
          end
        endcase
      end
    end
  end

  assign rdata_o = rdata_q;

  // A message slot is the bit position that carries the alarm message.
  assign slot_hit = ce_i && bit_valid_i && (bit_kind_i == KIND_MSG);
  assign start_evt = ce_i && (msg_state_q == MSG_IDLE) &&
                     alarm_msg_go_q && alarm_msg_enable_q; // [RULE10]
  assign done_evt = ce_i && (msg_state_q == MSG_DONE);

  // Sender state machine.
  always_comb begin
    msg_state_d = msg_state_q;
    case (msg_state_q)
      MSG_IDLE: begin
        if (start_evt) begin
          msg_state_d = MSG_SEND; // [RULE11]
        end
      end
      MSG_SEND: begin
        if (!alarm_msg_enable_q) begin
          msg_state_d = MSG_IDLE; // [RULE10]
        end else if (slot_hit && (bit_cnt_q == 4'(MSG_BITS - 1)) &&
                     (rep_cnt_q == 4'(MSG_REPEATS - 1))) begin
          msg_state_d = MSG_DONE; // [RULE11]
        end
      end
      MSG_DONE: begin
        msg_state_d = MSG_IDLE;
      end
      default: begin
        msg_state_d = MSG_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      msg_state_q <= MSG_IDLE;
    end else if (ce_i) begin
      msg_state_q <= msg_state_d;
    end
  end

  // Message shifter and counters; the code is captured when sending starts.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      msg_shift_q <= '1;
      bit_cnt_q <= 4'h0;
      rep_cnt_q <= 4'h0;
    end else if (ce_i) begin
      if (start_evt) begin
        msg_shift_q <= {MSG_FLAG, 1'b0, alarm_msg_code_q, 1'b0}; // [RULE11]
        bit_cnt_q <= 4'h0;
        rep_cnt_q <= 4'h0;
      end else if ((msg_state_q == MSG_SEND) && slot_hit) begin
        msg_shift_q <= {msg_shift_q[0], msg_shift_q[MSG_BITS-1:1]};
        bit_cnt_q <= bit_cnt_q + 4'h1;
        if (bit_cnt_q == 4'(MSG_BITS - 1)) begin
          bit_cnt_q <= 4'h0;
          rep_cnt_q <= rep_cnt_q + 4'h1; // [RULE11]
        end
      end
    end
  end

  assign alarm_msg_busy_o = (msg_state_q != MSG_IDLE); // [RULE12]
  assign irq_o = alarm_msg_irq_status_q && alarm_msg_irq_enable_q; // [RULE14] [RULE17]

  // Payload pattern phase advances on payload bits only.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pat_phase_q <= 2'h0;
    end else if (ce_i && bit_valid_i && (bit_kind_i == KIND_PAYLOAD)) begin
      pat_phase_q <= pat_phase_q + 2'h1;
    end
  end

  // Outbound bit selection, strongest condition first.
  always_comb begin
    out_bit = tx_bit_i;
    if (simulate_signal_loss) begin
      out_bit = 1'b0; // [RULE8]
    end else if (send_alarm_indication) begin
      case (bit_kind_i)
        KIND_PAYLOAD: out_bit = ~pat_phase_q[0]; // [RULE7]
        KIND_X: out_bit = 1'b1; // [RULE7]
        KIND_C, KIND_MSG: out_bit = 1'b0; // [RULE7]
        default: out_bit = tx_bit_i;
      endcase
    end else if (send_idle) begin // [RULE6]
      case (bit_kind_i)
        KIND_PAYLOAD: out_bit = (pat_phase_q < PAT_IDLE - 2'h1); // [RULE5]
        KIND_X: out_bit = 1'b1; // [RULE5]
        KIND_C: out_bit = (subframe_i == CP_SUBFRAME) ? 1'b0 : tx_bit_i; // [RULE5]
        KIND_MSG: out_bit = (msg_state_q == MSG_SEND) ? msg_shift_q[0] : 1'b1;
        default: out_bit = tx_bit_i;
      endcase
    end else begin
      case (bit_kind_i)
        KIND_X: begin
          if (yellow_cmd) begin
            out_bit = 1'b0; // [RULE1] [RULE2]
          end else if (force_x_ones) begin
            out_bit = 1'b1; // [RULE3] [RULE4]
          end else begin
            out_bit = ~auto_yellow; // [RULE1] [RULE9]
          end
        end
        // Only the sending state drives the slot, so the completion cycle adds no bit.
        KIND_MSG: out_bit = (msg_state_q == MSG_SEND) ? msg_shift_q[0] : 1'b1; // [RULE15]
        default: out_bit = tx_bit_i;
      endcase
    end
  end

  // Registered outbound stream.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_bit_q <= 1'b0;
      tx_valid_q <= 1'b0;
    end else if (ce_i) begin
      tx_valid_q <= bit_valid_i;
      tx_bit_q <= bit_valid_i ? out_bit : 1'b0;
    end
  end

  assign tx_bit_o = tx_bit_q;
  assign tx_valid_o = tx_valid_q;

endmodule

`default_nettype wire

// ### ds3_tx_oh_monitor.sv
// Port checker for the DS3 transmit overhead and alarm message controller.
`timescale 1ns/100ps
`default_nettype none
module ds3_tx_oh_monitor
  import ds3_tx_oh_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock, reset and register port.
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // Stream and status.
  input wire logic bit_valid_i,
  input wire logic [2:0] bit_kind_i,
  input wire logic [2:0] subframe_i,
  input wire logic tx_bit_o,
  input wire logic tx_valid_o,
  input wire logic alarm_msg_busy_o,
  input wire logic irq_o
);
  logic [7:0] cfg_q;
  logic ien_q;
  logic men_q;
  logic v;
  assign v = ce_i && bit_valid_i;
  // Shadow copies of the control bits, updated by the same writes as the design.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_q <= CFG_RESET;
      ien_q <= 1'b0;
      men_q <= 1'b0;
    end else if (ce_i && wr_i && addr_i == CFG_OFFSET) begin
      cfg_q <= wdata_i;
    end else if (ce_i && wr_i && addr_i == MSG_CTRL_OFFSET) begin
      ien_q <= wdata_i[CTRL_IRQ_EN_BIT];
      men_q <= wdata_i[CTRL_ENABLE_BIT];
    end
  end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  property p_los; v && cfg_q[3] |=> tx_valid_o && !tx_bit_o; endproperty
  a_los: assert property (p_los) else $error("line not zero");
  property p_ais; v && cfg_q[4:3] == 2'b10 && bit_kind_i == KIND_C |=> !tx_bit_o; endproperty
  a_ais: assert property (p_ais) else $error("ais c bit high");
  property p_idle; v && cfg_q[5:3] == 3'b100 && bit_kind_i == KIND_C && subframe_i == CP_SUBFRAME
    |=> !tx_bit_o; endproperty
  a_idle: assert property (p_idle) else $error("idle cp bit high");
  property p_yel; v && cfg_q[7:3] == 5'h10 && bit_kind_i == KIND_X |=> !tx_bit_o; endproperty
  a_yel: assert property (p_yel) else $error("yellow x bit high");
  property p_ones; v && cfg_q[7:3] == 5'h08 && bit_kind_i == KIND_X |=> tx_bit_o; endproperty
  a_ones: assert property (p_ones) else $error("forced x bit low");
  property p_mask; !ien_q |-> !irq_o; endproperty
  a_mask: assert property (p_mask) else $error("masked irq high");
  property p_done; $fell(alarm_msg_busy_o) && men_q && ien_q |-> ##[0:2] irq_o; endproperty
  a_done: assert property (p_done) else $error("no irq at end");
  property p_off; !men_q ##1 !men_q |-> !alarm_msg_busy_o; endproperty
  a_off: assert property (p_off) else $error("busy while disabled");
  property p_rd; rd_i && ce_i && addr_i == CFG_OFFSET |=> rdata_o == $past(cfg_q); endproperty
  a_rd: assert property (p_rd) else $error("config readback");
endmodule
`default_nettype wire

// ### ds3_line_model.sv
// Line interface model that collects every outbound bit.
`timescale 1ns/100ps
`default_nettype none
module ds3_line_model (
  // Outbound stream.
  input wire logic clk_i,
  input wire logic valid_i,
  input wire logic bit_i
);
  logic rxq[$];
  // Sampled away from the launching edge.
  always @(negedge clk_i) begin
    if (valid_i === 1'b1) begin
      rxq.push_back(bit_i);
    end
  end
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the DS3 transmit overhead and alarm message controller.
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import ds3_tx_oh_pkg::*;
;
  logic ref_clk_i = 0, rst_n_i = 0, ce_i = 1, wr_i = 0, rd_i = 0, bit_valid_i = 0, tx_bit_i = 0;
  logic rx_los_i = 0, rx_oof_i = 0, rx_ais_i = 0, chk_on = 0, ev = 0, eb = 0, exp_bit;
  logic tx_valid_o, tx_bit_o, alarm_msg_busy_o, irq_o;
  logic [7:0] addr_i = 0, wdata_i = 0, mcfg = CFG_RESET, c, rdata_o;
  logic [2:0] bit_kind_i = 0, subframe_i = 0;
  logic [1:0] ph = 0;
  logic [5:0] code;
  logic [4:0] tab[8] = '{5'h00, 5'h10, 5'h08, 5'h18, 5'h04, 5'h02, 5'h01, 5'h1F};
  int n_errors = 0, compares = 0, k;
  ds3_tx_overhead_alarm_ctrl #(.ADDR_W(8)) dut (.ref_clk_i, .rst_n_i, .ce_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .rx_los_i, .rx_oof_i, .rx_ais_i, .bit_valid_i, .bit_kind_i,
    .subframe_i, .tx_bit_i, .tx_valid_o, .tx_bit_o, .alarm_msg_busy_o, .irq_o);
  ds3_line_model u_line (.clk_i(ref_clk_i), .valid_i(tx_valid_o), .bit_i(tx_bit_o));
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  function automatic logic f(logic [7:0] c, logic [2:0] k, logic [2:0] s, logic b, logic [1:0] p,
    logic [2:0] r);
    if (c[3]) return 1'b0;
    if (c[4]) return (k == KIND_PAYLOAD) ? ~p[0] : (k == KIND_MFP) ? b : (k == KIND_X);
    case (k)
      KIND_PAYLOAD: return c[5] ? ~p[1] : b;
      KIND_X: return c[5] | (~c[7] & (c[6] | ~|(r & c[2:0])));
      KIND_C: return ~(c[5] && s == CP_SUBFRAME) & b;
      KIND_MSG: return 1'b1;
      default: return b;
    endcase
  endfunction
  task give_verdict();
    if (n_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    rd_i <= 1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 0;
    @(negedge ref_clk_i);
    chk(rdata_o, e);
  endtask
  task step(input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      bit_valid_i <= 1'($urandom);
      bit_kind_i <= 3'($urandom_range(4));
      subframe_i <= 3'($urandom);
      tx_bit_i <= 1'($urandom);
      ce_i <= ($urandom_range(7) != 0);
      {rx_los_i, rx_oof_i, rx_ais_i} <= 3'($urandom);
    end
  endtask
  // Reference stream model, one cycle behind the inputs like the design.
  // A low clock enable freezes the model exactly as it freezes the design.
  always @(posedge ref_clk_i) begin
    if (ce_i) begin
      if (wr_i && addr_i == CFG_OFFSET) mcfg <= wdata_i;
      if (bit_valid_i && bit_kind_i == KIND_PAYLOAD) ph <= ph + 2'h1;
      ev <= bit_valid_i;
      eb <= bit_valid_i & f(mcfg, bit_kind_i, subframe_i, tx_bit_i, ph,
        {rx_los_i, rx_oof_i, rx_ais_i});
    end
  end
  always @(negedge ref_clk_i) begin
    if (chk_on) begin
      chk(8'(tx_valid_o), 8'(ev));
      chk(8'(tx_bit_o), 8'(eb));
    end
  end
  initial begin
    #100000;
    n_errors++;
    give_verdict();
  end
  initial begin
    void'($urandom(8));
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1;
    repeat (3) @(posedge ref_clk_i);
    rd(CFG_OFFSET, CFG_RESET);
    rd(MSG_CTRL_OFFSET, 8'h00);
    rd(MSG_CODE_OFFSET, {1'b0, CODE_RESET, 1'b0});
    rd(8'h33, 8'h00);
    chk_on = 1;
    for (int i = 0; i < 16; i++) begin
      c = 8'($urandom);
      if (i < 8) c[7:3] = tab[i];
      wr(CFG_OFFSET, c);
      step(40);
    end
    chk_on = 0;
    @(posedge ref_clk_i);
    ce_i <= 1'b1;
    code = 6'($urandom);
    wr(CFG_OFFSET, 8'h00);
    wr(MSG_CODE_OFFSET, {1'b0, code, 1'b0});
    rd(MSG_CODE_OFFSET, {1'b0, code, 1'b0});
    @(posedge ref_clk_i);
    bit_valid_i <= 1;
    bit_kind_i <= KIND_MSG;
    wr(MSG_CTRL_OFFSET, 8'h16);
    // Older random stream bits are already out of the line by now.
    u_line.rxq.delete();
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk(8'(alarm_msg_busy_o), 8'h01);
    // Go starts one edge after the write; 160 slots and one completion cycle follow,
    // so busy is first seen low 159 falling edges after this point.
    for (k = 0; k < 400 && alarm_msg_busy_o !== 1'b0; k++) @(negedge ref_clk_i);
    chk(8'(k), 8'h9F);
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk(8'(irq_o), 8'h01);
    wr(MSG_CTRL_OFFSET, 8'h04);
    @(negedge ref_clk_i);
    chk(8'(irq_o), 8'h00);
    rd(MSG_CTRL_OFFSET, 8'h0C);
    rd(MSG_CTRL_OFFSET, 8'h04);
    while (u_line.rxq.size() > 0 && u_line.rxq[0] === 1'b1) void'(u_line.rxq.pop_front());
    for (int r = 0; r < 160; r++) begin
      k = r % 16;
      exp_bit = (k == 0 || k == 7) ? 1'b0 : (k < 7) ? code[k-1] : 1'b1;
      chk(8'(u_line.rxq.pop_front()), 8'(exp_bit));
    end
    chk(8'(u_line.rxq.pop_front()), 8'h01);
    wr(MSG_CTRL_OFFSET, 8'h02);
    u_line.rxq.delete();
    repeat (200) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk(8'(alarm_msg_busy_o), 8'h00);
    foreach (u_line.rxq[i]) chk(8'(u_line.rxq[i]), 8'h01);
    give_verdict();
  end
endmodule
bind ds3_tx_overhead_alarm_ctrl ds3_tx_oh_monitor #(.ADDR_W(ADDR_W)) u_mon (.ref_clk_i,
  .rst_n_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .bit_valid_i, .bit_kind_i,
  .subframe_i, .tx_bit_o, .tx_valid_o, .alarm_msg_busy_o, .irq_o);
`default_nettype wire
